// [rtl/scs_defines.svh]
/*
 * register offsets, field positions, reset values and switch timing
 * for the system clock source switch; included by the design files.
 * assumes a 32-bit APB bus with byte addresses on an 8-bit paddr.
 */
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

// register byte offsets
`define SCS_OFF_OSC_CTRL 8'h00
`define SCS_OFF_TUNE 8'h04
`define SCS_OFF_T1_CTRL 8'h08
`define SCS_OFF_STATUS 8'h0c

// oscillator_control_reg fields
`define SCS_SEL_LSB 0
`define SCS_INTERNAL_STABLE_FLAG_BIT 2
`define SCS_PRIMARY_RUNNING_FLAG_BIT 3
`define SCS_FREQ_LSB 4
`define SCS_IDLE_BIT 7

// oscillator_tuning_reg fields
`define SCS_TUNE_LSB 0
`define SCS_FREQ_MULTIPLIER_ENABLE_BIT 6
`define SCS_LFSRC_BIT 7

// timer1_control_reg fields
`define SCS_T1EN_BIT 3
`define SCS_SECONDARY_RUNNING_FLAG_BIT 6

// status register fields
`define SCS_STAT_CFG_LSB 0
`define SCS_STAT_SRC_LSB 4
`define SCS_STAT_BUSY_BIT 8

// reset values
`define SCS_SEL_RST 2'h0
`define SCS_FREQ_RST 3'h4
`define SCS_TUNE_RST 5'h00

// encodings
`define SCS_SEL_SEC 2'h1
`define SCS_FREQ_LF 3'h0
`define SCS_CFG_INT_A 4'h8
`define SCS_CFG_INT_B 4'h9

// switch pause, in cycles of the old and of the new source
`define SCS_OLD_CYCLES 2'h2
`define SCS_NEW_CYCLES 2'h3
// strap settle time after reset release, in pclk cycles
`define SCS_STRAP_WAIT 2'h3

`endif

// [rtl/scs_pkg.sv]
/*
 * types of the system clock source switch: states, sources, bus carriers.
 * assumes scs_defines.svh supplies the numeric constants.
 */
package scs_pkg;

	typedef enum logic [2:0] {
		SCS_SW_IDLE = 3'b001,
		SCS_SW_OLD = 3'b010,
		SCS_SW_NEW = 3'b100
	} scs_sw_state_t;

	typedef enum logic [1:0] {
		SCS_SRC_PRI = 2'h0,
		SCS_SRC_SEC = 2'h1,
		SCS_SRC_INT = 2'h2
	} scs_src_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} scs_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} scs_apb_rsp_t;

	typedef struct packed {
		logic pri_tick;
		logic sec_tick;
		logic int_tick;
		logic ost_done;
		logic int_stable;
	} scs_osc_in_t;

endpackage

// [rtl/scs_sync.sv]
/*
 * two-flop level synchroniser, one lane per bit.
 * assumes inputs are asynchronous to pclk; each lane settles on its own.
 */
`timescale 1ns/10ps
module scs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // scs_sync

// [rtl/scs_clock_switch.sv]
/*
 * system clock source switch: control registers on APB, glitch-free
 * source change sequencing, clock-running flags and internal block setup.
 * assumes oscillator ticks and status levels arrive asynchronously and
 * the primary_mode_config strap is stable from reset onward.
 */
// Contract
// - two-bit select picks primary, secondary or internal block as system clock
// - a select write starts a move to the new source after a short pause
// - every reset clears the source select to zero
// - three-bit frequency select picks rc source, 8 MHz, or postscaled rates
// - frequency select changes the internal block output one pclk after the write
// - internal block output frequency resets to 1 MHz
// - at 000 the low-frequency bit picks fast source /256 or rc source
// - watchdog and fail-safe monitor always run from the rc source
// - primary-running flag set once start-up timed out and primary clocks
// - internal-stable flag set when internal block is stable and clocking
// - secondary-running flag at bit 6 of timer1 control register
// - at most one running flag at a time; none means rc or unstable
// - sleep instruction enters idle or sleep according to idle enable
// - secondary select ignored unless secondary oscillator enable is set
// - switch pauses two old-source plus three to four new-source cycles
// - four primary config bits choose the primary oscillator mode
// - secondary oscillator may keep running in power-managed modes
// - frequency multiplier works only in internal config at 4 or 8 MHz
`timescale 1ns/10ps
`include "scs_defines.svh"
module scs_clock_switch (
	input wire logic pclk,
	input wire logic presetn,
	input wire scs_pkg::scs_apb_req_t apb_req,
	output scs_pkg::scs_apb_rsp_t apb_rsp,
	input wire scs_pkg::scs_osc_in_t osc_in,
	input wire logic [3:0] primary_mode_config,
	input wire logic sleep_exec,
	output logic sys_clk_enable,
	output scs_pkg::scs_src_t active_source,
	output logic [2:0] int_freq_out,
	output logic int_div256_sel,
	output logic pll_active,
	output logic wdt_clk_from_rc,
	output logic secondary_osc_run,
	output logic sleep_entry,
	output logic idle_entry
);
	import scs_pkg::*;

	logic [8:0] sync_q;
	logic [2:0] tick_prev_q, tick_rise;
	logic ost_sync, int_stable_sync;
	logic [1:0] strap_cnt_q, sel_q, sw_cnt_q, sel_wr;
	logic [3:0] cfg_q;
	logic pri_is_int;
	logic [2:0] freq_q;
	logic idle_q, lfsrc_q, freq_multiplier_enable_q, t1en_q;
	logic [4:0] tune_q;
	logic primary_running_flag_q, internal_stable_flag_q, secondary_running_flag_q;
	scs_sw_state_t sw_state_q;
	scs_src_t pend_src_q, target_src;
	logic old_tick, new_tick, acc_phase, wr_fire, addr_hit;
	logic [31:0] rdata_d;

	// async oscillator inputs and strap resynchronised before use
	scs_sync #(.WIDTH(9)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({primary_mode_config, osc_in.ost_done, osc_in.int_stable,
			osc_in.int_tick, osc_in.sec_tick, osc_in.pri_tick}),
		.q(sync_q)
	);

	assign ost_sync = sync_q[4];
	assign int_stable_sync = sync_q[3];
	// tick edges are taken off the settled stage only
	assign tick_rise = sync_q[2:0] & ~tick_prev_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_prev_q <= 3'h0;
		end else begin
			tick_prev_q <= sync_q[2:0];
		end
	end

	// strap caught once the synchroniser has filled after release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_cnt_q <= 2'h0;
			cfg_q <= 4'h0;
		end else if (strap_cnt_q != `SCS_STRAP_WAIT) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			if (strap_cnt_q == `SCS_STRAP_WAIT - 2'h1) begin
				cfg_q <= sync_q[8:5];
			end
		end
	end

	assign pri_is_int = (cfg_q == `SCS_CFG_INT_A) || (cfg_q == `SCS_CFG_INT_B);

	// apb: one wait state, write lands on the edge that sees pready high
	assign acc_phase = apb_req.psel && apb_req.penable;
	assign wr_fire = acc_phase && apb_rsp.pready && apb_req.pwrite;
	assign addr_hit = (apb_req.paddr == `SCS_OFF_OSC_CTRL) || (apb_req.paddr == `SCS_OFF_TUNE)
		|| (apb_req.paddr == `SCS_OFF_T1_CTRL) || (apb_req.paddr == `SCS_OFF_STATUS);

	always_comb begin
		rdata_d = 32'h0;
		case (apb_req.paddr)
			`SCS_OFF_OSC_CTRL: begin
				rdata_d[`SCS_IDLE_BIT] = idle_q;
				rdata_d[`SCS_FREQ_LSB +: 3] = freq_q;
				rdata_d[`SCS_PRIMARY_RUNNING_FLAG_BIT] = primary_running_flag_q;
				rdata_d[`SCS_INTERNAL_STABLE_FLAG_BIT] = internal_stable_flag_q;
				rdata_d[`SCS_SEL_LSB +: 2] = sel_q;
			end
			`SCS_OFF_TUNE: begin
				rdata_d[`SCS_LFSRC_BIT] = lfsrc_q;
				// multiplier enable reads zero unless the primary config is internal
				rdata_d[`SCS_FREQ_MULTIPLIER_ENABLE_BIT] = freq_multiplier_enable_q && pri_is_int;
				rdata_d[`SCS_TUNE_LSB +: 5] = tune_q;
			end
			`SCS_OFF_T1_CTRL: begin
				rdata_d[`SCS_SECONDARY_RUNNING_FLAG_BIT] = secondary_running_flag_q;
				rdata_d[`SCS_T1EN_BIT] = t1en_q;
			end
			`SCS_OFF_STATUS: begin
				rdata_d[`SCS_STAT_CFG_LSB +: 4] = cfg_q;
				rdata_d[`SCS_STAT_SRC_LSB +: 2] = active_source;
				rdata_d[`SCS_STAT_BUSY_BIT] = (sw_state_q != SCS_SW_IDLE);
			end
			default: rdata_d = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_rsp <= '0;
		end else begin
			apb_rsp.pready <= acc_phase && !apb_rsp.pready;
			if (acc_phase && !apb_rsp.pready) begin
				apb_rsp.prdata <= apb_req.pwrite ? 32'h0 : rdata_d;
				apb_rsp.pslverr <= !addr_hit;
			end else begin
				apb_rsp.pslverr <= 1'b0;
			end
		end
	end

	// a secondary request without its oscillator enabled keeps the old select
	assign sel_wr = apb_req.pwdata[`SCS_SEL_LSB +: 2];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q <= `SCS_SEL_RST;
			freq_q <= `SCS_FREQ_RST;
			idle_q <= 1'b0;
		end else if (wr_fire && apb_req.paddr == `SCS_OFF_OSC_CTRL) begin
			if (!(sel_wr == `SCS_SEL_SEC && !t1en_q)) begin
				sel_q <= sel_wr;
			end
			freq_q <= apb_req.pwdata[`SCS_FREQ_LSB +: 3];
			idle_q <= apb_req.pwdata[`SCS_IDLE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfsrc_q <= 1'b0;
			freq_multiplier_enable_q <= 1'b0;
			tune_q <= `SCS_TUNE_RST;
		end else if (wr_fire && apb_req.paddr == `SCS_OFF_TUNE) begin
			lfsrc_q <= apb_req.pwdata[`SCS_LFSRC_BIT];
			freq_multiplier_enable_q <= apb_req.pwdata[`SCS_FREQ_MULTIPLIER_ENABLE_BIT];
			tune_q <= apb_req.pwdata[`SCS_TUNE_LSB +: 5];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t1en_q <= 1'b0;
		end else if (wr_fire && apb_req.paddr == `SCS_OFF_T1_CTRL) begin
			t1en_q <= apb_req.pwdata[`SCS_T1EN_BIT];
		end
	end

	// select code 1x means internal block
	always_comb begin
		case (sel_q)
			2'h0: target_src = SCS_SRC_PRI;
			2'h1: target_src = SCS_SRC_SEC;
			default: target_src = SCS_SRC_INT;
		endcase
	end

	always_comb begin
		case (active_source)
			SCS_SRC_PRI: old_tick = tick_rise[0];
			SCS_SRC_SEC: old_tick = tick_rise[1];
			default: old_tick = tick_rise[2];
		endcase
		case (pend_src_q)
			SCS_SRC_PRI: new_tick = tick_rise[0];
			SCS_SRC_SEC: new_tick = tick_rise[1];
			default: new_tick = tick_rise[2];
		endcase
	end

	// clock held off for the whole switch; a stopped new source stalls here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_state_q <= SCS_SW_IDLE;
			sw_cnt_q <= 2'h0;
			pend_src_q <= SCS_SRC_PRI;
			active_source <= SCS_SRC_PRI;
			sys_clk_enable <= 1'b1;
		end else begin
			case (sw_state_q)
				SCS_SW_IDLE: begin
					if (target_src != active_source) begin
						sw_state_q <= SCS_SW_OLD;
						sw_cnt_q <= 2'h0;
						pend_src_q <= target_src;
						sys_clk_enable <= 1'b0;
					end
				end
				SCS_SW_OLD: begin
					if (old_tick) begin
						if (sw_cnt_q == `SCS_OLD_CYCLES - 2'h1) begin
							sw_state_q <= SCS_SW_NEW;
							sw_cnt_q <= 2'h0;
						end else begin
							sw_cnt_q <= sw_cnt_q + 2'h1;
						end
					end
				end
				SCS_SW_NEW: begin
					if (new_tick) begin
						if (sw_cnt_q == `SCS_NEW_CYCLES - 2'h1) begin
							sw_state_q <= SCS_SW_IDLE;
							sw_cnt_q <= 2'h0;
							active_source <= pend_src_q;
							sys_clk_enable <= 1'b1;
						end else begin
							sw_cnt_q <= sw_cnt_q + 2'h1;
						end
					end
				end
				default: begin
					sw_state_q <= SCS_SW_IDLE;
					sw_cnt_q <= 2'h0;
					sys_clk_enable <= 1'b1;
				end
			endcase
		end
	end

	// flags only while settled, so two can never overlap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primary_running_flag_q <= 1'b0;
			internal_stable_flag_q <= 1'b0;
			secondary_running_flag_q <= 1'b0;
		end else begin
			primary_running_flag_q <= sys_clk_enable && active_source == SCS_SRC_PRI
				&& !pri_is_int && ost_sync;
			internal_stable_flag_q <= sys_clk_enable && int_stable_sync
				&& (active_source == SCS_SRC_INT || (active_source == SCS_SRC_PRI && pri_is_int))
				&& !(freq_q == `SCS_FREQ_LF && !lfsrc_q);
			secondary_running_flag_q <= sys_clk_enable && active_source == SCS_SRC_SEC;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_freq_out <= `SCS_FREQ_RST;
			int_div256_sel <= 1'b0;
			pll_active <= 1'b0;
			wdt_clk_from_rc <= 1'b1;
			secondary_osc_run <= 1'b0;
		end else begin
			int_freq_out <= freq_q;
			int_div256_sel <= (freq_q == `SCS_FREQ_LF) && lfsrc_q;
			pll_active <= freq_multiplier_enable_q && pri_is_int && (freq_q[2:1] == 2'b11);
			wdt_clk_from_rc <= 1'b1;
			// not stopped by sleep or idle entry
			secondary_osc_run <= t1en_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_entry <= 1'b0;
			idle_entry <= 1'b0;
		end else begin
			sleep_entry <= sleep_exec && !idle_q;
			idle_entry <= sleep_exec && idle_q;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_old_done;
		sw_state_q == SCS_SW_OLD && old_tick && sw_cnt_q == 2'h1;
	endsequence
	sequence s_new_done;
		sw_state_q == SCS_SW_NEW && new_tick && sw_cnt_q == 2'h2;
	endsequence

	chk_reset_sel_clear: assert property ($rose(presetn) |-> sel_q == 2'h0)
		else $error("select not clear after reset");
	chk_sec_refused: assert property (wr_fire && apb_req.paddr == `SCS_OFF_OSC_CTRL
		&& sel_wr == 2'h1 && !t1en_q |=> sel_q == $past(sel_q))
		else $error("secondary select taken while oscillator disabled");
	chk_flags_exclusive: assert property ($onehot0({primary_running_flag_q, internal_stable_flag_q, secondary_running_flag_q}))
		else $error("more than one running flag set");
	chk_old_two_ticks: assert property (s_old_done |=> sw_state_q == SCS_SW_NEW
		&& !sys_clk_enable)
		else $error("old source phase did not end after two ticks");
	chk_new_resume: assert property (s_new_done |=> sys_clk_enable
		&& active_source == $past(pend_src_q))
		else $error("clock did not resume on new source");
	chk_freq_follow: assert property ($changed(freq_q) |=> int_freq_out == $past(freq_q))
		else $error("internal output did not follow frequency select");
	chk_pll_gated: assert property (pll_active |-> $past(pri_is_int)
		&& $past(freq_q[2:1]) == 2'b11)
		else $error("multiplier active outside allowed setup");
	chk_sleep_idle: assert property (sleep_exec |=> idle_entry == $past(idle_q)
		&& sleep_entry == !$past(idle_q))
		else $error("sleep entry does not match idle enable");
	chk_lowfreq_src: assert property (freq_q == 3'h0 && lfsrc_q |=> int_div256_sel)
		else $error("divide-by-256 source not selected");
	chk_pri_flag: assert property (primary_running_flag_q |-> $past(active_source) == SCS_SRC_PRI
		&& $past(ost_sync))
		else $error("primary flag set without primary clocking");
endmodule // scs_clock_switch

// [tb/scs_osc_model.sv]
/*
 * oscillator partner: three source ticks, start-up timer and stability levels.
 * assumes pclk as time base; the secondary crystal only runs while enabled.
 */
`timescale 1ns/10ps
module scs_osc_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sec_en,
	output scs_pkg::scs_osc_in_t osc_in
);
	import scs_pkg::*;
	logic [7:0] cnt_q;
	// periods 6, 10 and 4 pclk; wrap at 240 keeps every half >= 2
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 8'h00;
			osc_in <= '0;
		end else begin
			cnt_q <= (cnt_q == 8'hef) ? 8'h00 : cnt_q + 8'h01;
			if (cnt_q % 3 == 0) osc_in.pri_tick <= !osc_in.pri_tick;
			// crystal stands still while its enable is low
			if (sec_en && cnt_q % 5 == 0) osc_in.sec_tick <= !osc_in.sec_tick;
			if (cnt_q % 2 == 0) osc_in.int_tick <= !osc_in.int_tick;
			osc_in.ost_done <= osc_in.ost_done | (cnt_q == 8'h04);
			osc_in.int_stable <= osc_in.int_stable | (cnt_q == 8'h06);
		end
	end
endmodule // scs_osc_model

// [tb/system_clock_source_switch_test.sv]
/*
 * self-checking bench for the clock source switch, registers over APB.
 * assumes scs_osc_model on the oscillator side and a 25 MHz pclk.
 */
`timescale 1ns/10ps
`include "scs_defines.svh"
module system_clock_source_switch_test;
	import scs_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	scs_apb_req_t req = '0;
	scs_apb_rsp_t rsp;
	scs_osc_in_t osc;
	logic [3:0] cfg = 4'h2;
	logic sleep_exec = 1'b0;
	logic clk_en, div256, pll, wdt_rc, sec_run, slp, idl;
	scs_src_t src;
	logic [2:0] freq;
	logic [31:0] rd;
	logic last_err;
	int err_total = 0;
	int samples_checked = 0;
	always #20 pclk = ~pclk;
	scs_clock_switch scs_clock_switch_inst (.pclk(pclk), .presetn(presetn), .apb_req(req),
		.apb_rsp(rsp), .osc_in(osc), .primary_mode_config(cfg), .sleep_exec(sleep_exec),
		.sys_clk_enable(clk_en), .active_source(src), .int_freq_out(freq),
		.int_div256_sel(div256), .pll_active(pll), .wdt_clk_from_rc(wdt_rc),
		.secondary_osc_run(sec_run), .sleep_entry(slp), .idle_entry(idl));
	scs_osc_model scs_osc_model_inst (.pclk(pclk), .presetn(presetn), .sec_en(sec_run),
		.osc_in(osc));
	task automatic report_and_stop;
		if (err_total == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	function automatic logic [31:0] cw(logic [1:0] s, logic [2:0] f, logic i);
		return {24'h0, i, f, 2'b00, s};
	endfunction
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (rsp.pready !== 1'b1) begin
			err_total++;
			report_and_stop();
		end
		rd = rsp.prdata;
		last_err = rsp.pslverr;
		req <= '0;
	endtask
	task automatic settle;
		repeat (3) @(posedge pclk);
	endtask
	task automatic do_reset;
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (12) @(posedge pclk);
	endtask
	task automatic do_switch(input logic [1:0] s, input scs_src_t exp);
		int n;
		int low;
		apb(1'b1, `SCS_OFF_OSC_CTRL, cw(s, 3'h4, 1'b0));
		n = 0;
		low = 0;
		while (clk_en !== 1'b0 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		while (clk_en !== 1'b1 && low < 400) begin
			@(posedge pclk);
			low++;
		end
		if (n >= 20 || low >= 400) begin
			err_total++;
			report_and_stop();
		end
		chk("pause_len", low >= 10, 1);
		chk("active_source", src, exp);
		settle();
		apb(1'b0, `SCS_OFF_STATUS, 0);
		chk("stat_src", rd[5:4], exp);
	endtask
	task automatic t_reset_vals;
		apb(1'b0, `SCS_OFF_OSC_CTRL, 0);
		chk("sel_rst", rd[1:0], 0);
		chk("freq_rst", rd[6:4], 3'h4);
		chk("pri_flag", rd[3:2], 2'h2);
		chk("freq_out", freq, 3'h4);
		chk("wdt_rc", wdt_rc, 1);
		apb(1'b0, `SCS_OFF_STATUS, 0);
		chk("cfg_seen", rd[3:0], cfg);
		apb(1'b0, 8'h20, 0);
		chk("unmapped_err", last_err, 1);
		chk("unmapped_rd", rd, 0);
	endtask
	task automatic t_sec_refused;
		apb(1'b1, `SCS_OFF_OSC_CTRL, cw(2'h1, 3'h5, 1'b0));
		apb(1'b0, `SCS_OFF_OSC_CTRL, 0);
		chk("sec_ignored", {rd[6:4], rd[1:0]}, {3'h5, 2'h0});
		settle();
		chk("no_switch", {clk_en, src}, {1'b1, SCS_SRC_PRI});
	endtask
	task automatic t_freq;
		for (int f = 0; f < 8; f++) begin
			apb(1'b1, `SCS_OFF_OSC_CTRL, cw(2'h2, f[2:0], 1'b0));
			settle();
			chk("freq_out", freq, f[2:0]);
		end
		apb(1'b1, `SCS_OFF_OSC_CTRL, cw(2'h2, 3'h0, 1'b0));
		apb(1'b1, `SCS_OFF_TUNE, 32'h80);
		settle();
		chk("div256_on", div256, 1);
		apb(1'b1, `SCS_OFF_TUNE, 32'h00);
		settle();
		chk("div256_off", div256, 0);
		apb(1'b0, `SCS_OFF_OSC_CTRL, 0);
		chk("rc_no_flag", rd[3:2], 0);
		apb(1'b1, `SCS_OFF_OSC_CTRL, cw(2'h2, 3'h4, 1'b0));
	endtask
	task automatic t_sleep;
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, `SCS_OFF_OSC_CTRL, cw(2'h0, 3'h4, i[0]));
			@(posedge pclk);
			sleep_exec <= 1'b1;
			@(posedge pclk);
			sleep_exec <= 1'b0;
			#1;
			chk("sleep_kind", {slp, idl}, {!i[0], i[0]});
		end
	endtask
	initial begin
		do_reset();
		t_reset_vals();
		t_sec_refused();
		do_switch(2'h2, SCS_SRC_INT);
		apb(1'b0, `SCS_OFF_OSC_CTRL, 0);
		chk("int_flag", rd[3:2], 2'h1);
		t_freq();
		apb(1'b1, `SCS_OFF_T1_CTRL, 32'h08);
		settle();
		chk("sec_run", sec_run, 1);
		// crystal given time to start before it is selected
		repeat (30) @(posedge pclk);
		do_switch(2'h1, SCS_SRC_SEC);
		apb(1'b0, `SCS_OFF_T1_CTRL, 0);
		chk("sec_flag", rd[6], 1);
		apb(1'b0, `SCS_OFF_OSC_CTRL, 0);
		chk("sec_only", rd[3:2], 0);
		do_switch(2'h0, SCS_SRC_PRI);
		apb(1'b0, `SCS_OFF_T1_CTRL, 0);
		chk("sec_flag_off", rd[6], 0);
		t_sleep();
		apb(1'b1, `SCS_OFF_TUNE, 32'h40);
		apb(1'b1, `SCS_OFF_OSC_CTRL, cw(2'h2, 3'h7, 1'b0));
		apb(1'b0, `SCS_OFF_TUNE, 0);
		chk("pll_forced", {rd[6], pll}, 0);
		cfg <= 4'h8;
		do_reset();
		apb(1'b0, `SCS_OFF_OSC_CTRL, 0);
		chk("sel_rst2", {rd[6:4], rd[1:0]}, {3'h4, 2'h0});
		chk("int_cfg_flag", rd[3:2], 2'h1);
		apb(1'b0, `SCS_OFF_STATUS, 0);
		chk("cfg_int", rd[3:0], 4'h8);
		apb(1'b1, `SCS_OFF_OSC_CTRL, cw(2'h0, 3'h7, 1'b0));
		apb(1'b1, `SCS_OFF_TUNE, 32'h40);
		apb(1'b0, `SCS_OFF_TUNE, 0);
		settle();
		chk("pll_on", {rd[6], pll}, 2'h3);
		apb(1'b1, `SCS_OFF_OSC_CTRL, cw(2'h0, 3'h5, 1'b0));
		settle();
		chk("pll_off", pll, 0);
		report_and_stop();
	end
endmodule // system_clock_source_switch_test
